// ---- rtl/rlo_ctrl.sv ----
// Purpose: regenerator maintenance control: deactivation, loopback 1A, alarm reporting
// Assumes: line fault and alarm sources are asynchronous pins, channel and crc strobes are on clk_sys
// Notes:   registers at byte offsets 0x0 control and 0x4 status, other reads return zero
//
// Summary of operation
// - any line loss of signal or framing deactivates both line sides.
// - loopback closes the cycle after an own-address loop request.
// - looped signal still travels onward toward the network terminal.
// - channel stays operational for messages carrying address 10.
// - foreign address during loopback answers hold state with own address.
// - indicators loop back except presence, alarm and both block errors.
// - return-to-normal deactivates customer transceiver and cancels loopback.
// - after release with network link up, restart customer-side activation.
// - loop entry may hold the customer transceiver in reset to reconverge.
// - network terminal alarm bit is forwarded upstream.
// - own internal failures raise the regenerator alarm bit upstream.
// - alarm sources: clock loss, pair delay difference, memory test fail.
// - both power source failure bits are forwarded upstream separately.
// - application loss-of-signal bit forwarded when enabled.
// - bipolar violation bit forwarded only when enabled.
// - network-side crc errors raise own block error bit upstream.
// - customer-side crc errors raise own block error bit upstream.
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ps
module rlo_ctrl #(
  parameter logic [7:0] LOOP_CODE = 8'h01,
  parameter logic [7:0] RTN_CODE  = 8'h02,
  parameter logic [7:0] HOLD_CODE = 8'h03
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_n,
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  input  wire logic              net_los,
  input  wire logic              net_lfa,
  input  wire logic              cust_los,
  input  wire logic              cust_lfa,
  input  wire logic              clk_src_lost,
  input  wire logic              delay_diff_exceeded,
  input  wire logic              mem_test_fail,
  input  wire logic              net_link_up,
  input  wire logic              eoc_rx_valid,
  input  wire rlo_pkg::rlo_eoc_t eoc_rx,
  output logic                   eoc_tx_valid,
  output rlo_pkg::rlo_eoc_t      eoc_tx,
  input  wire logic              frame_tick,
  input  wire logic              net_crc_err,
  input  wire logic              cust_crc_err,
  input  wire rlo_pkg::rlo_ind_t ind_from_ltu,
  input  wire rlo_pkg::rlo_ind_t ind_from_ntu,
  output rlo_pkg::rlo_ind_t      ind_to_ltu,
  output rlo_pkg::rlo_ind_t      ind_to_ntu,
  output logic                   net_side_act,
  output logic                   cust_side_act,
  output logic                   loop_close,
  output logic                   cust_xcvr_reset,
  output logic                   cust_start
);

  // ==========================================================
  // pin synchronisation
  logic [rlo_pkg::PIN_W-1:0] pins_raw;
  logic [rlo_pkg::PIN_W-1:0] pins_s;

  assign pins_raw = {net_link_up, mem_test_fail, delay_diff_exceeded, clk_src_lost,
                     cust_lfa, cust_los, net_lfa, net_los};

  rlo_sync #(
    .WIDTH (rlo_pkg::PIN_W)
  ) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .din     (pins_raw),
    .dout    (pins_s)
  );

  // ==========================================================
  // decoded conditions
  wire logic       los_any;
  wire logic       int_fail;
  wire logic       net_up_s;
  wire logic       own_msg;
  wire logic       loop_req;
  wire logic       rtn_req;
  wire logic       in_loop;
  wire logic [3:0] line_fault;

  assign line_fault = {pins_s[rlo_pkg::PIN_CUST_LFA], pins_s[rlo_pkg::PIN_CUST_LOS],
                       pins_s[rlo_pkg::PIN_NET_LFA], pins_s[rlo_pkg::PIN_NET_LOS]};
  assign los_any    = |line_fault;
  assign int_fail   = pins_s[rlo_pkg::PIN_CLK_LOST] | pins_s[rlo_pkg::PIN_DLY_DIFF]
                    | pins_s[rlo_pkg::PIN_MEM_FAIL];
  assign net_up_s   = pins_s[rlo_pkg::PIN_NET_UP];
  // only the line terminal addresses us, so no local loop trigger exists
  assign own_msg    = eoc_rx_valid && (eoc_rx.addr == rlo_pkg::OWN_ADDR);
  assign loop_req   = own_msg && (eoc_rx.code == LOOP_CODE);
  assign rtn_req    = own_msg && (eoc_rx.code == RTN_CODE);

  // ==========================================================
  // control register
  rlo_pkg::rlo_ctrl_t ctrl;
  wire logic          wr_ctrl;

  assign wr_ctrl = reg_wr && (reg_addr == rlo_pkg::REG_CTRL);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ctrl <= rlo_pkg::CTRL_RESET;
    end else if (wr_ctrl) begin
      ctrl <= reg_wdata[rlo_pkg::CTRL_W-1:0];
    end
  end

  // ==========================================================
  // state machine
  rlo_pkg::rlo_state_t state;
  rlo_pkg::rlo_state_t next_state;
  logic [rlo_pkg::CNT_W-1:0] rst_cnt;
  logic [rlo_pkg::CNT_W-1:0] next_rst_cnt;
  localparam logic [rlo_pkg::CNT_W-1:0] RST_LAST = rlo_pkg::CNT_W'(rlo_pkg::REGC_RESET_CYC - 1);

  assign in_loop = (state == rlo_pkg::ST_LOOP_SYNC) || (state == rlo_pkg::ST_LOOP);

  // line faults override every other transition
  always_comb begin
    next_state   = state;
    next_rst_cnt = '0;
    if (los_any) begin
      next_state = rlo_pkg::ST_IDLE;
    end else begin
      case (state)
        rlo_pkg::ST_IDLE: begin
          next_state = rlo_pkg::ST_ACTIVE;
        end
        rlo_pkg::ST_ACTIVE: begin
          // accepted whether start-up is still running or the link is up
          if (loop_req) begin
            next_state = ctrl.sync_reset_en ? rlo_pkg::ST_LOOP_SYNC : rlo_pkg::ST_LOOP;
          end
        end
        rlo_pkg::ST_LOOP_SYNC: begin
          if (rtn_req) begin
            next_state = rlo_pkg::ST_RELEASE;
          end else if (rst_cnt == RST_LAST) begin
            next_state = rlo_pkg::ST_LOOP;
          end else begin
            next_rst_cnt = rst_cnt + 1'b1;
          end
        end
        rlo_pkg::ST_LOOP: begin
          if (rtn_req) begin
            next_state = rlo_pkg::ST_RELEASE;
          end
        end
        rlo_pkg::ST_RELEASE: begin
          next_state = rlo_pkg::ST_ACTIVE;
        end
        default: begin
          next_state = rlo_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // registered line controls
  wire logic next_net_act;
  wire logic next_cust_act;
  wire logic next_loop;
  wire logic next_cust_rst;
  wire logic next_cust_start;

  assign next_net_act    = (next_state != rlo_pkg::ST_IDLE);
  assign next_cust_act   = (next_state != rlo_pkg::ST_IDLE)
                        && (next_state != rlo_pkg::ST_RELEASE);
  assign next_loop       = (next_state == rlo_pkg::ST_LOOP_SYNC)
                        || (next_state == rlo_pkg::ST_LOOP);
  assign next_cust_rst   = (next_state == rlo_pkg::ST_LOOP_SYNC);
  // restart only makes sense while the upstream link still holds
  assign next_cust_start = (state == rlo_pkg::ST_RELEASE) && (next_state == rlo_pkg::ST_ACTIVE)
                        && net_up_s;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      state           <= rlo_pkg::ST_IDLE;
      rst_cnt         <= '0;
      net_side_act    <= 1'b0;
      cust_side_act   <= 1'b0;
      loop_close      <= 1'b0;
      cust_xcvr_reset <= 1'b0;
      cust_start      <= 1'b0;
    end else begin
      state           <= next_state;
      rst_cnt         <= next_rst_cnt;
      net_side_act    <= next_net_act;
      cust_side_act   <= next_cust_act;
      loop_close      <= next_loop;
      cust_xcvr_reset <= next_cust_rst;
      cust_start      <= next_cust_start;
    end
  end

  // ==========================================================
  // operations channel answers
  rlo_pkg::rlo_eoc_t hold_msg;
  rlo_pkg::rlo_eoc_t next_tx;
  wire logic         foreign_in_loop;
  wire logic         next_tx_valid;

  assign hold_msg        = '{addr: rlo_pkg::OWN_ADDR, code: HOLD_CODE};
  assign foreign_in_loop = eoc_rx_valid && in_loop && (eoc_rx.addr != rlo_pkg::OWN_ADDR);
  // own messages are echoed, which keeps the channel running in loop too
  assign next_tx_valid   = own_msg || foreign_in_loop;
  assign next_tx         = own_msg ? eoc_rx : hold_msg;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      eoc_tx_valid <= 1'b0;
      eoc_tx       <= '0;
    end else begin
      eoc_tx_valid <= next_tx_valid;
      eoc_tx       <= next_tx;
    end
  end

  // ==========================================================
  // alarm and indicators
  logic reg_alarm;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_alarm <= 1'b0;
    end else begin
      reg_alarm <= int_fail | ctrl.force_alarm;
    end
  end

  rlo_indsel u_indsel (
    .clk_sys      (clk_sys),
    .rst_n        (rst_n),
    .loop_active  (loop_close),
    .frame_tick   (frame_tick),
    .net_crc_err  (net_crc_err),
    .cust_crc_err (cust_crc_err),
    .reg_alarm    (reg_alarm),
    .los_en       (ctrl.los_en),
    .bpv_en       (ctrl.bpv_en),
    .ind_from_ltu (ind_from_ltu),
    .ind_from_ntu (ind_from_ntu),
    .ind_to_ltu   (ind_to_ltu),
    .ind_to_ntu   (ind_to_ntu)
  );

  // ==========================================================
  // register read port
  rlo_pkg::rlo_status_t status_word;
  wire logic [31:0]     rd_mux;

  assign status_word = '{rsvd_hi: '0, net_up: net_up_s, reg_alarm: reg_alarm,
                         line_fault: line_fault, rsvd_lo: '0, state: state};
  assign rd_mux = (reg_addr == rlo_pkg::REG_CTRL)   ? {{(32-rlo_pkg::CTRL_W){1'b0}}, ctrl} :
                  (reg_addr == rlo_pkg::REG_STATUS) ? status_word : 32'h0;

  // data valid only in the cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 32'h0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0;
    end
  end

  // ==========================================================
  // checks
  sequence s_loop_req_active;
    (state == rlo_pkg::ST_ACTIVE) && loop_req && !los_any;
  endsequence

  sequence s_release_up;
    in_loop && rtn_req && !los_any ##1 (net_up_s && !los_any);
  endsequence

  a_los_deact: assert property (@(posedge clk_sys) disable iff (!rst_n)
    los_any |=> !net_side_act && !cust_side_act && !loop_close)
    else $error("line fault did not deactivate both sides");

  a_loop_close: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_loop_req_active |=> loop_close && (state != rlo_pkg::ST_ACTIVE))
    else $error("loop request did not close loopback");

  a_hold_reply: assert property (@(posedge clk_sys) disable iff (!rst_n)
    foreign_in_loop |=> eoc_tx_valid && eoc_tx.code == HOLD_CODE && eoc_tx.addr == rlo_pkg::OWN_ADDR)
    else $error("no hold state answer to foreign address");

  a_own_echo: assert property (@(posedge clk_sys) disable iff (!rst_n)
    own_msg |=> eoc_tx_valid && eoc_tx == $past(eoc_rx))
    else $error("own-address message not answered");

  a_rtn_release: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (in_loop && rtn_req && !los_any) |=> !loop_close && !cust_side_act && net_side_act)
    else $error("return to normal did not release loopback");

  a_ntu_restart: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_release_up |=> cust_start && cust_side_act)
    else $error("customer side not restarted after release");

  a_sync_reset: assert property (@(posedge clk_sys) disable iff (!rst_n || los_any || rtn_req)
    $rose(cust_xcvr_reset) |-> (cust_xcvr_reset && loop_close)[*8])
    else $error("customer transceiver reset too short");

  a_alarm_raise: assert property (@(posedge clk_sys) disable iff (!rst_n)
    int_fail |=> reg_alarm ##1 ind_to_ltu.reg_alarm)
    else $error("internal failure not reported upstream");

  a_fwd_rta: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !loop_close |=> ind_to_ltu.rta == $past(ind_from_ntu.rta))
    else $error("remote terminal alarm not forwarded");

  a_transparent: assert property (@(posedge clk_sys) disable iff (!rst_n)
    loop_close |=> ind_to_ntu == $past(ind_from_ltu))
    else $error("downstream not forwarded during loopback");

endmodule

// ---- rtl/rlo_indsel.sv ----
// Purpose: overhead indicator steering toward line terminal and network terminal
// Assumes: frame_tick marks the frame in which indicator bits are sent
// Notes:   block error flags are held until the next frame tick
`timescale 1ns/1ps
module rlo_indsel (
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            loop_active,
  input  wire logic            frame_tick,
  input  wire logic            net_crc_err,
  input  wire logic            cust_crc_err,
  input  wire logic            reg_alarm,
  input  wire logic            los_en,
  input  wire logic            bpv_en,
  input  wire rlo_pkg::rlo_ind_t ind_from_ltu,
  input  wire rlo_pkg::rlo_ind_t ind_from_ntu,
  output rlo_pkg::rlo_ind_t    ind_to_ltu,
  output rlo_pkg::rlo_ind_t    ind_to_ntu
);

  // ==========================================================
  // block error flags
  logic              rrbe_q;
  logic              rcbe_q;
  rlo_pkg::rlo_ind_t up_base;
  rlo_pkg::rlo_ind_t up_next;

  // error arriving on the tick cycle survives the clear
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rrbe_q <= 1'b0;
      rcbe_q <= 1'b0;
    end else begin
      rrbe_q <= net_crc_err | (rrbe_q & ~frame_tick);
      rcbe_q <= cust_crc_err | (rcbe_q & ~frame_tick);
    end
  end

  // ==========================================================
  // upstream selection
  // loop takes the downstream bits back, own bits always stay live
  assign up_base = loop_active ? ind_from_ltu : ind_from_ntu;

  always_comb begin
    up_next                       = up_base;
    up_next.presence              = 1'b1;
    up_next.reg_alarm             = reg_alarm;
    up_next.rrbe                  = rrbe_q | net_crc_err;
    up_next.rcbe                  = rcbe_q | cust_crc_err;
    up_next.los_app               = up_base.los_app & los_en;
    up_next.bpv                   = up_base.bpv & bpv_en;
  end

  // downstream is always forwarded, loop or not
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ind_to_ltu <= '0;
      ind_to_ntu <= '0;
    end else begin
      ind_to_ltu <= up_next;
      ind_to_ntu <= ind_from_ltu;
    end
  end

  a_loop_return: assert property (@(posedge clk_sys) disable iff (!rst_n)
    loop_active |=> ind_to_ltu.rta == $past(ind_from_ltu.rta) && ind_to_ltu.presence)
    else $error("indicator bit not looped back");

  a_rrbe_report: assert property (@(posedge clk_sys) disable iff (!rst_n)
    net_crc_err |=> ind_to_ltu.rrbe)
    else $error("network side block error not reported");

endmodule

// ---- rtl/rlo_pkg.sv ----
// Purpose: shared constants and carriers for the regenerator loopback and maintenance block
// Assumes: 40 MHz system clock, word-wide register port with byte addresses
// Notes:   indicator bits and operations-channel messages travel as packed structs
package rlo_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS  = 25;
  localparam int REGC_RESET_NS  = 1000;  // customer-side transceiver reset on loop entry
  localparam int REGC_RESET_RAW = (REGC_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int REGC_RESET_CYC = (REGC_RESET_RAW < 1) ? 1 : REGC_RESET_RAW;
  localparam int CNT_W          = 6;

  // ==========================================================
  // operations channel
  localparam logic [1:0] OWN_ADDR = 2'h2;  // regenerator address "10"

  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] code;
  } rlo_eoc_t;

  // ==========================================================
  // overhead indicator bits
  typedef struct packed {
    logic presence;
    logic reg_alarm;
    logic rrbe;
    logic rcbe;
    logic rta;
    logic power_source_one_fail;
    logic power_source_two_fail;
    logic los_app;
    logic bpv;
  } rlo_ind_t;

  // ==========================================================
  // synchronised pin vector layout
  localparam int PIN_NET_LOS   = 0;
  localparam int PIN_NET_LFA   = 1;
  localparam int PIN_CUST_LOS  = 2;
  localparam int PIN_CUST_LFA  = 3;
  localparam int PIN_CLK_LOST  = 4;
  localparam int PIN_DLY_DIFF  = 5;
  localparam int PIN_MEM_FAIL  = 6;
  localparam int PIN_NET_UP    = 7;
  localparam int PIN_W         = 8;

  // ==========================================================
  // register map
  localparam logic [3:0] REG_CTRL   = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam int         CTRL_W     = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h8;  // only sync reset enabled

  typedef struct packed {
    logic sync_reset_en;
    logic bpv_en;
    logic los_en;
    logic force_alarm;
  } rlo_ctrl_t;

  typedef enum logic [4:0] {
    ST_IDLE      = 5'h01,
    ST_ACTIVE    = 5'h02,
    ST_LOOP_SYNC = 5'h04,
    ST_LOOP      = 5'h08,
    ST_RELEASE   = 5'h10
  } rlo_state_t;

  typedef struct packed {
    logic [17:0] rsvd_hi;
    logic        net_up;
    logic        reg_alarm;
    logic [3:0]  line_fault;
    logic [2:0]  rsvd_lo;
    logic [4:0]  state;
  } rlo_status_t;

endpackage

// ---- rtl/rlo_sync.sv ----
// Purpose: two-stage synchroniser for asynchronous level inputs
// Assumes: inputs are slow levels, not pulses
// Notes:   only the second stage may be read
`timescale 1ns/1ps
module rlo_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  // ==========================================================
  // stages
  logic [WIDTH-1:0] meta;

  // first stage feeds nothing but the second
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      meta <= '0;
      dout <= '0;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end

endmodule

// ---- sim/rlo_ltu_model.sv ----
// Purpose: line terminal controller model on the operations channel
// Assumes: one message per call, same clock as the block
// Notes:   idle payload is inverted so a stale word never looks valid
`timescale 1ns/1ps
module rlo_ltu_model (
  input  wire logic         clk_sys,
  output logic              eoc_rx_valid,
  output rlo_pkg::rlo_eoc_t eoc_rx
);
  // ==========================================================
  // message driver
  initial begin
    eoc_rx_valid = 1'b0;
    eoc_rx       = '0;
  end
  // loop request and release start only here
  task automatic send(input logic [1:0] addr, input logic [7:0] code);
    @(posedge clk_sys);
    eoc_rx_valid <= 1'b1;
    eoc_rx       <= '{addr: addr, code: code};
    @(posedge clk_sys);
    eoc_rx_valid <= 1'b0;
    eoc_rx       <= rlo_pkg::rlo_eoc_t'(~eoc_rx);  // released, not held
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for the regenerator maintenance block
// Assumes: 40 MHz clock, sync active-low reset
// Notes:   replies and read data are matched against queued notes
`timescale 1ns/1ps
module tb_top;
  logic              clk_sys, rst_n, reg_wr, reg_rd, rd_d, frame_tick, net_link_up;
  logic              eoc_rx_valid, eoc_tx_valid, net_side_act, cust_side_act;
  logic              loop_close, cust_xcvr_reset, cust_start;
  logic [3:0]        reg_addr;
  logic [31:0]       reg_wdata, reg_rdata;
  logic [6:0]        flt;
  logic [1:0]        crc;
  rlo_pkg::rlo_eoc_t eoc_rx, eoc_tx;
  rlo_pkg::rlo_ind_t ind_from_ltu, ind_from_ntu, ind_to_ltu, ind_to_ntu;
  rlo_pkg::rlo_eoc_t eoc_q[$];
  logic [31:0]       rd_q[$];
  int                n_mismatch, n_compared, k;
  // ==========================================================
  // design and far side
  rlo_ctrl dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .net_los(flt[0]), .net_lfa(flt[1]), .cust_los(flt[2]),
    .cust_lfa(flt[3]), .clk_src_lost(flt[4]), .delay_diff_exceeded(flt[5]), .mem_test_fail(flt[6]),
    .net_link_up(net_link_up), .eoc_rx_valid(eoc_rx_valid), .eoc_rx(eoc_rx), .eoc_tx_valid(eoc_tx_valid),
    .eoc_tx(eoc_tx), .frame_tick(frame_tick), .net_crc_err(crc[0]), .cust_crc_err(crc[1]),
    .ind_from_ltu(ind_from_ltu), .ind_from_ntu(ind_from_ntu), .ind_to_ltu(ind_to_ltu), .ind_to_ntu(ind_to_ntu),
    .net_side_act(net_side_act), .cust_side_act(cust_side_act), .loop_close(loop_close),
    .cust_xcvr_reset(cust_xcvr_reset), .cust_start(cust_start));
  rlo_ltu_model ltu (.clk_sys(clk_sys), .eoc_rx_valid(eoc_rx_valid), .eoc_rx(eoc_rx));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  // ==========================================================
  // compare and bus tasks
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_eoc(input string w, input rlo_pkg::rlo_eoc_t e, input rlo_pkg::rlo_eoc_t g);
    cmp(w, 32'(e), 32'(g));
  endtask
  task automatic cmp_ind(input string w, input rlo_pkg::rlo_ind_t e, input rlo_pkg::rlo_ind_t g);
    cmp(w, 32'(e), 32'(g));
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
  endtask
  function automatic rlo_pkg::rlo_ind_t exp_ind(rlo_pkg::rlo_ind_t b, logic [3:0] c);
    exp_ind           = b;
    exp_ind.presence  = 1'b1;
    exp_ind.reg_alarm = 1'b0;
    exp_ind.rrbe      = 1'b0;
    exp_ind.rcbe      = 1'b0;
    exp_ind.los_app   = b.los_app & c[1];
    exp_ind.bpv       = b.bpv & c[2];
  endfunction
  task automatic end_sim;
    n_mismatch += eoc_q.size() + rd_q.size();  // notes never answered
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ==========================================================
  // monitor: oldest note against each result
  always @(posedge clk_sys) rd_d <= reg_rd;
  always @(negedge clk_sys) begin
    if (eoc_tx_valid === 1'b1) begin
      if (eoc_q.size() == 0) cmp("eoc_reply_unexpected", 32'h0, 32'h1);
      else cmp_eoc("eoc_tx", eoc_q.pop_front(), eoc_tx);
    end
    if (rd_d === 1'b1 && rd_q.size() != 0) cmp("reg_rdata", rd_q.pop_front(), reg_rdata);
  end
  // ==========================================================
  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, frame_tick, reg_addr, reg_wdata, flt, crc} = '0;
    {ind_from_ltu, ind_from_ntu} = '0;
    net_link_up = 1'b1;
    n_mismatch = 0;
    n_compared = 0;
    void'($urandom(32'h6f94149b));
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle(4);
    rd(rlo_pkg::REG_CTRL, 32'h8);
    rd(rlo_pkg::REG_STATUS, 32'h2002);
    rd(4'h8, 32'h0);
    @(posedge clk_sys);
    ind_from_ltu <= 9'($urandom());
    ind_from_ntu <= 9'($urandom());
    ltu.send(2'h1, 8'h55);  // foreign address outside loop: silence
    settle(2);
    cmp_ind("ind_to_ltu", exp_ind(ind_from_ntu, 4'h8), ind_to_ltu);
    cmp_ind("ind_to_ntu", ind_from_ltu, ind_to_ntu);
    wr(rlo_pkg::REG_CTRL, 32'hfe);
    rd(rlo_pkg::REG_CTRL, 32'he);
    $display("test regs done");
    // loop entry on an active link, customer transceiver held in reset
    eoc_q.push_back('{addr: rlo_pkg::OWN_ADDR, code: dut.LOOP_CODE});
    ltu.send(rlo_pkg::OWN_ADDR, dut.LOOP_CODE);
    settle(0);
    cmp("loop_close", 32'h1, 32'(loop_close));
    cmp("cust_xcvr_reset", 32'h1, 32'(cust_xcvr_reset));
    @(posedge clk_sys);
    ind_from_ltu <= 9'($urandom());
    settle(2);
    cmp_ind("ind_to_ltu", exp_ind(ind_from_ltu, 4'he), ind_to_ltu);
    cmp_ind("ind_to_ntu", ind_from_ltu, ind_to_ntu);
    settle(30);
    cmp("cust_xcvr_reset_hold", 32'h1, 32'(cust_xcvr_reset));
    settle(15);
    cmp("cust_xcvr_reset", 32'h0, 32'(cust_xcvr_reset));
    rd(rlo_pkg::REG_STATUS, 32'h2008);
    eoc_q.push_back('{addr: rlo_pkg::OWN_ADDR, code: dut.HOLD_CODE});
    ltu.send(2'h3, 8'h55);
    eoc_q.push_back('{addr: rlo_pkg::OWN_ADDR, code: 8'h5a});
    ltu.send(rlo_pkg::OWN_ADDR, 8'h5a);
    // own block error bits keep working inside the loop
    for (int j = 0; j < 2; j++) begin
      @(posedge clk_sys);
      crc[j] <= 1'b1;
      @(posedge clk_sys);
      crc[j] <= 1'b0;
      settle(2);
      cmp("block_err", (j == 0) ? 32'h2 : 32'h1, 32'({ind_to_ltu.rrbe, ind_to_ltu.rcbe}));
      @(posedge clk_sys);
      frame_tick <= 1'b1;
      @(posedge clk_sys);
      frame_tick <= 1'b0;
      settle(2);
      cmp("block_err_clr", 32'h0, 32'({ind_to_ltu.rrbe, ind_to_ltu.rcbe}));
    end
    $display("test loop done");
    // release, then restart toward the network terminal
    eoc_q.push_back('{addr: rlo_pkg::OWN_ADDR, code: dut.RTN_CODE});
    ltu.send(rlo_pkg::OWN_ADDR, dut.RTN_CODE);
    settle(0);
    cmp("release_act", 32'h0, 32'({loop_close, cust_side_act}));
    for (k = 0; k < 5 && cust_start !== 1'b1; k++) @(negedge clk_sys);
    cmp("cust_start", 32'h3, 32'({cust_start, cust_side_act}));
    $display("test release done");
    // line faults and internal alarm sources
    for (int i = 0; i < 7; i++) begin
      @(posedge clk_sys);
      flt[i] <= 1'b1;
      settle(6);
      if (i < 4) cmp("fault_act", 32'h0, 32'({net_side_act, cust_side_act}));
      else cmp("reg_alarm", 32'h1, 32'(ind_to_ltu.reg_alarm));
      rd(rlo_pkg::REG_STATUS, (i < 4) ? (32'h2001 | (32'h100 << i)) : 32'h3002);
      flt[i] <= 1'b0;
      settle(6);
      cmp("recover_act", 32'h3, 32'({net_side_act, cust_side_act}));
    end
    $display("test faults done");
    // loop without transceiver reset, forced alarm, release while the network link is down
    wr(rlo_pkg::REG_CTRL, 32'h1);
    eoc_q.push_back('{addr: rlo_pkg::OWN_ADDR, code: dut.LOOP_CODE});
    ltu.send(rlo_pkg::OWN_ADDR, dut.LOOP_CODE);
    settle(0);
    cmp("loop_direct", 32'h1, 32'({cust_xcvr_reset, loop_close}));
    cmp("reg_alarm_forced", 32'h1, 32'(ind_to_ltu.reg_alarm));
    rd(rlo_pkg::REG_STATUS, 32'h3008);
    @(posedge clk_sys);
    net_link_up <= 1'b0;
    eoc_q.push_back('{addr: rlo_pkg::OWN_ADDR, code: dut.RTN_CODE});
    ltu.send(rlo_pkg::OWN_ADDR, dut.RTN_CODE);
    settle(2);
    cmp("no_restart", 32'h1, 32'({cust_start, cust_side_act}));
    $display("test direct loop done");
    end_sim();
  end
endmodule
